// ---- common/int_arb_pkg.sv ----
// Package with constants and types for the interrupt arbitration block.
package int_arb_pkg;
  localparam int NUM_CH = 16;
  localparam int CH_W   = 4;
  localparam int PRL_W  = 3;
  localparam int VEC_W  = 8;
  localparam int PC_W   = 16;
  localparam int SEG_W  = 8;
  localparam int FLAG_W = 8;
  localparam int NEST_W = 8;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CPL    = 4'h1;
  localparam logic [3:0] ADDR_NEST   = 4'h2;
  localparam logic [3:0] ADDR_CSEG   = 4'h3;
  localparam logic [3:0] ADDR_ISEG   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // Control register field positions.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_IEN_BIT  = 1;
  localparam int CTRL_SSE_BIT  = 2;

  // Reset values.
  localparam logic [PRL_W-1:0]  CPL_RESET  = 3'h7;
  localparam logic [NEST_W-1:0] NEST_RESET = 8'h00;
  localparam logic [SEG_W-1:0]  SEG_RESET  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET   = 16'h0000;

  localparam logic [PC_W-1:0] ONE_PC = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_PCL    = 4'h1,
    ST_PCH    = 4'h3,
    ST_CSEG   = 4'h2,
    ST_FLAG   = 4'h6,
    ST_VLO    = 4'h7,
    ST_VHI    = 4'h5,
    ST_RFLAG  = 4'h4,
    ST_RCSEG  = 4'hC,
    ST_RPCH   = 4'hD,
    ST_RPCL   = 4'hF
  } seq_state_t;

  typedef struct packed {
    logic [NUM_CH-1:0]            pend;
    logic [NUM_CH*PRL_W-1:0]      channel_priority_level;
    logic [NUM_CH*VEC_W-1:0]      vec;
  } chan_req_t;

  typedef struct packed {
    logic             push;
    logic             pop;
    logic             rd;
    logic [PC_W-1:0]  addr;
    logic [7:0]       wdata;
  } mem_req_t;

  typedef struct packed {
    logic             ack;
    logic [CH_W-1:0]  chan;
    logic [PRL_W-1:0] channel_priority_level;
    logic [VEC_W-1:0] vec;
  } ack_t;
endpackage : int_arb_pkg

// ---- rtl/interrupt_arbitration_nesting.sv ----
// Interrupt arbitration with concurrent and nested modes and entry sequencing.
`timescale 1ns/1ps
//
// Operation
// RULE1: Mode bit clear selects concurrent, the reset value; set selects nested.
// RULE2: Concurrent mode arbitrates each instruction and never changes priority.
// RULE3: Acknowledge first clears the global enable bit.
// RULE4: Entry pushes PC low, PC high, code segment if saving, then flags.
// RULE5: PC is loaded with a 16-bit vector picked by the vector register.
// RULE6: Saving copies int segment to code segment; else fetch uses int segment.
// RULE7: Return pops flags, code segment if saving, PC high, then PC low.
// RULE8: Return sets the global enable bit.
// RULE9: Concurrent return without saving fetches from the code segment again.
// RULE10: Nested return keeps int segment while returning into a nested routine.
// RULE11: Pending requests wait until enable is set by ei or return.
// RULE12: Concurrent mode keeps no routine priority; any raised request is taken. The code never takes a level 7 request.
// RULE13: Software should use ei only in nested mode.
// RULE14: Concurrent nesting needs segment saving or equal segments.
// RULE15: Nested acknowledge sets the stack bit indexed by current priority.
// RULE16: Nested acknowledge loads current priority with the request priority.
// RULE17: Nested entry: clear enable, save level, load level, push, vector.
// RULE18: Nested return restores current priority from the priority stack.
// RULE19: The stack pop takes the lowest set bit and clears it.
// RULE20: Acknowledge carries the channel priority and vector the same cycle.
// RULE21: A request wins only with priority strictly below the current level.
// RULE22: Current priority resets to 7.
// RULE23: Equal priorities resolve to the lowest channel index, daisy first.
module interrupt_arbitration_nesting (
  // Clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_N,
  // Register port
  input  wire logic [3:0]                 REG_ADDR,
  input  wire logic [7:0]                 REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic [7:0]                      REG_RDATA,
  // Interrupt channels
  input  wire int_arb_pkg::chan_req_t     CHAN_REQ,
  output int_arb_pkg::ack_t               CHAN_ACK,
  // Sequencer control
  input  wire logic                       INSTR_BOUNDARY,
  input  wire logic                       EI_INSTR,
  input  wire logic                       DI_INSTR,
  input  wire logic                       IRET_INSTR,
  input  wire logic [int_arb_pkg::PC_W-1:0]   PC_IN,
  input  wire logic [int_arb_pkg::FLAG_W-1:0] FLAGS_IN,
  // Stack and vector memory
  output int_arb_pkg::mem_req_t           MEM_REQ,
  input  wire logic [7:0]                 MEM_RDATA,
  input  wire logic                       MEM_DONE,
  // Results toward the core
  output logic                            PC_LOAD,
  output logic [int_arb_pkg::PC_W-1:0]    PC_OUT,
  output logic                            FLAGS_LOAD,
  output logic [int_arb_pkg::FLAG_W-1:0]  FLAGS_OUT,
  output logic [int_arb_pkg::SEG_W-1:0]   FETCH_SEG,
  output logic                            BUSY
);
  import int_arb_pkg::*;

  logic             mode_ff, nxt_mode;
  logic             ien_ff, nxt_ien;
  logic             sse_ff, nxt_sse;
  logic [PRL_W-1:0] cpl_ff, nxt_cpl;
  logic [NEST_W-1:0] nest_ff, nxt_nest;
  logic [SEG_W-1:0] cseg_ff, nxt_cseg;
  logic [SEG_W-1:0] iseg_ff, nxt_iseg;
  logic             use_iseg_ff, nxt_use_iseg;
  seq_state_t       st_ff, nxt_st;
  logic [PC_W-1:0]  pc_ff, nxt_pc;
  logic [PC_W-1:0]  pcret_ff, nxt_pcret;
  logic [VEC_W-1:0] vec_ff, nxt_vec;
  logic [FLAG_W-1:0] flag_ff, nxt_flag;
  logic [7:0]       rdata_ff, nxt_rdata;
  logic             pcld_ff, nxt_pcld;
  logic             flld_ff, nxt_flld;

  // Arbiter: lowest index wins among equals, so scan from the top down.
  logic             win_v;
  logic [CH_W-1:0]  win_ch;
  logic [PRL_W-1:0] win_prl;
  logic [VEC_W-1:0] win_vec;
  logic             take;

  always_comb begin
    win_v   = 1'b0;
    win_ch  = '0;
    win_prl = CPL_RESET;
    win_vec = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (CHAN_REQ.pend[i] &&
          (!win_v || CHAN_REQ.channel_priority_level[i*PRL_W +: PRL_W] <= win_prl)) begin // see RULE23
        win_v   = 1'b1;
        win_ch  = CH_W'(i);
        win_prl = CHAN_REQ.channel_priority_level[i*PRL_W +: PRL_W];
        win_vec = CHAN_REQ.vec[i*VEC_W +: VEC_W];
      end
    end
  end

  // Acknowledge waits for an idle sequencer, so one entry runs at a time.
  // Requests stay pending outside while enable is clear. // see RULE11
  assign take = win_v && (win_prl < cpl_ff) && ien_ff &&
                INSTR_BOUNDARY && (st_ff == ST_IDLE); // see RULE21

  always_comb begin
    CHAN_ACK.ack  = take;
    CHAN_ACK.chan = win_ch;
    CHAN_ACK.channel_priority_level  = win_prl; // see RULE20
    CHAN_ACK.vec  = win_vec; // see RULE20
  end

  // Each nested save records a lower level, so the lowest set bit is newest.
  // Lowest set bit of the priority stack.
  logic [PRL_W-1:0] nest_low;
  logic             nest_any;
  always_comb begin
    nest_low = CPL_RESET;
    nest_any = 1'b0;
    for (int j = NEST_W - 1; j >= 0; j--) begin
      if (nest_ff[j]) begin
        nest_low = PRL_W'(j); // see RULE19
        nest_any = 1'b1;
      end
    end
  end

  // Register and sequencer next state.
  always_comb begin
    logic [NEST_W-1:0] popped;
    popped       = nest_ff;
    nxt_mode     = mode_ff;
    nxt_ien      = ien_ff;
    nxt_sse      = sse_ff;
    nxt_cpl      = cpl_ff;
    nxt_nest     = nest_ff;
    nxt_cseg     = cseg_ff;
    nxt_iseg     = iseg_ff;
    nxt_use_iseg = use_iseg_ff;
    nxt_st       = st_ff;
    nxt_pc       = pc_ff;
    nxt_pcret    = pcret_ff;
    nxt_vec      = vec_ff;
    nxt_flag     = flag_ff;
    nxt_pcld     = 1'b0;
    nxt_flld     = 1'b0;
    nxt_rdata    = 8'h00;
    MEM_REQ      = '0;

    // Read data are registered and stand only in the cycle after the strobe.
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_CTRL:   nxt_rdata = {5'h00, sse_ff, ien_ff, mode_ff};
        ADDR_CPL:    nxt_rdata = {5'h00, cpl_ff};
        ADDR_NEST:   nxt_rdata = nest_ff;
        ADDR_CSEG:   nxt_rdata = cseg_ff;
        ADDR_ISEG:   nxt_rdata = iseg_ff;
        ADDR_STATUS: nxt_rdata = {4'h0, st_ff};
        default:     nxt_rdata = 8'h00;
      endcase
    end
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_CTRL: begin
          nxt_mode = REG_WDATA[CTRL_MODE_BIT]; // see RULE1
          nxt_ien  = REG_WDATA[CTRL_IEN_BIT];
          nxt_sse  = REG_WDATA[CTRL_SSE_BIT];
        end
        ADDR_CPL:  nxt_cpl  = REG_WDATA[PRL_W-1:0];
        ADDR_NEST: nxt_nest = REG_WDATA;
        ADDR_CSEG: nxt_cseg = REG_WDATA;
        ADDR_ISEG: nxt_iseg = REG_WDATA;
        default: ;
      endcase
    end
    if (EI_INSTR) begin
      nxt_ien = 1'b1; // see RULE11
    end
    if (DI_INSTR) begin
      nxt_ien = 1'b0;
    end

    case (st_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_ien   = 1'b0; // see RULE3
          nxt_pcret = PC_IN;
          nxt_flag  = FLAGS_IN;
          nxt_vec   = win_vec;
          nxt_st    = ST_PCL;
          if (mode_ff) begin
            nxt_nest[cpl_ff] = 1'b1; // see RULE15
            nxt_cpl = win_prl; // see RULE16
          end
          // Concurrent mode keeps no level record. // see RULE2 RULE12
        end else if (IRET_INSTR) begin
          nxt_st = ST_RFLAG;
        end
      end

      ST_PCL: begin // see RULE17
        MEM_REQ.push  = 1'b1;
        MEM_REQ.wdata = pcret_ff[7:0]; // see RULE4
        if (MEM_DONE) nxt_st = ST_PCH;
      end

      ST_PCH: begin
        MEM_REQ.push  = 1'b1;
        MEM_REQ.wdata = pcret_ff[15:8]; // see RULE4
        if (MEM_DONE) nxt_st = sse_ff ? ST_CSEG : ST_FLAG;
      end

      ST_CSEG: begin
        MEM_REQ.push  = 1'b1;
        MEM_REQ.wdata = cseg_ff; // see RULE4
        if (MEM_DONE) nxt_st = ST_FLAG;
      end

      ST_FLAG: begin
        MEM_REQ.push  = 1'b1;
        MEM_REQ.wdata = flag_ff; // see RULE4
        if (MEM_DONE) nxt_st = ST_VLO;
      end

      // The first vector byte read becomes the high half of the new PC.
      ST_VLO: begin
        MEM_REQ.rd   = 1'b1;
        MEM_REQ.addr = {iseg_ff, vec_ff}; // see RULE5
        if (MEM_DONE) begin
          nxt_pc[15:8] = MEM_RDATA;
          nxt_st = ST_VHI;
        end
      end

      ST_VHI: begin
        MEM_REQ.rd   = 1'b1;
        MEM_REQ.addr = {iseg_ff, vec_ff} + ONE_PC;
        if (MEM_DONE) begin
          nxt_pc[7:0] = MEM_RDATA; // see RULE5
          nxt_pcld = 1'b1;
          nxt_st   = ST_IDLE;
          if (sse_ff) nxt_cseg = iseg_ff; // see RULE6
          else nxt_use_iseg = 1'b1; // see RULE6
        end
      end

      ST_RFLAG: begin
        MEM_REQ.pop = 1'b1; // see RULE7
        if (MEM_DONE) begin
          nxt_flag = MEM_RDATA;
          nxt_flld = 1'b1;
          nxt_st   = sse_ff ? ST_RCSEG : ST_RPCH;
        end
      end

      ST_RCSEG: begin
        MEM_REQ.pop = 1'b1;
        if (MEM_DONE) begin
          nxt_cseg = MEM_RDATA; // see RULE7
          nxt_st   = ST_RPCH;
        end
      end

      ST_RPCH: begin
        MEM_REQ.pop = 1'b1;
        if (MEM_DONE) begin
          nxt_pc[15:8] = MEM_RDATA; // see RULE7
          nxt_st = ST_RPCL;
        end
      end

      ST_RPCL: begin
        MEM_REQ.pop = 1'b1;
        if (MEM_DONE) begin
          nxt_pc[7:0] = MEM_RDATA; // see RULE7
          nxt_pcld = 1'b1;
          nxt_ien  = 1'b1; // see RULE8
          nxt_st   = ST_IDLE;
          if (mode_ff) begin
            popped[nest_low] = 1'b0;
            nxt_nest = popped; // see RULE19
            nxt_cpl  = nest_low; // see RULE18
            // Stay on the int segment while another routine is below. // see RULE10
            if (!sse_ff) nxt_use_iseg = (popped != NEST_RESET);
          end else if (!sse_ff) begin
            nxt_use_iseg = 1'b0; // see RULE9
          end
        end
      end

      default: nxt_st = ST_IDLE;
    endcase
  end

  // All state shares one asynchronous reset, and it loads constants only.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_ff     <= 1'b0; // see RULE1
      ien_ff      <= 1'b0;
      sse_ff      <= 1'b0;
      cpl_ff      <= CPL_RESET; // see RULE22
      nest_ff     <= NEST_RESET;
      cseg_ff     <= SEG_RESET;
      iseg_ff     <= SEG_RESET;
      use_iseg_ff <= 1'b0;
      st_ff       <= ST_IDLE;
      pc_ff       <= PC_RESET;
      pcret_ff    <= PC_RESET;
      vec_ff      <= '0;
      flag_ff     <= '0;
      rdata_ff    <= 8'h00;
      pcld_ff     <= 1'b0;
      flld_ff     <= 1'b0;
    end else begin
      mode_ff     <= nxt_mode;
      ien_ff      <= nxt_ien;
      sse_ff      <= nxt_sse;
      cpl_ff      <= nxt_cpl;
      nest_ff     <= nxt_nest;
      cseg_ff     <= nxt_cseg;
      iseg_ff     <= nxt_iseg;
      use_iseg_ff <= nxt_use_iseg;
      st_ff       <= nxt_st;
      pc_ff       <= nxt_pc;
      pcret_ff    <= nxt_pcret;
      vec_ff      <= nxt_vec;
      flag_ff     <= nxt_flag;
      rdata_ff    <= nxt_rdata;
      pcld_ff     <= nxt_pcld;
      flld_ff     <= nxt_flld;
    end
  end

  // Without segment saving a routine fetches from the interrupt segment.
  assign REG_RDATA  = rdata_ff;
  assign PC_LOAD    = pcld_ff;
  assign PC_OUT     = pc_ff;
  assign FLAGS_LOAD = flld_ff;
  assign FLAGS_OUT  = flag_ff;
  assign FETCH_SEG  = (use_iseg_ff && nest_any | use_iseg_ff) ? iseg_ff
                                                              : cseg_ff;
  assign BUSY       = (st_ff != ST_IDLE);
endmodule : interrupt_arbitration_nesting

// ---- verification/int_arb_sva.sv ----
// Port-level checker for the interrupt arbitration block.
`timescale 1ns/1ps
module int_arb_sva (
  // Clock, reset and control
  input wire logic                        REF_CLK,
  input wire logic                        RST_N,
  input wire logic [3:0]                  REG_ADDR,
  input wire logic                        REG_WR,
  input wire logic                        INSTR_BOUNDARY,
  input wire logic                        EI_INSTR,
  input wire logic                        IRET_INSTR,
  input wire logic [int_arb_pkg::PC_W-1:0] PC_IN,
  // Channels and memory
  input wire int_arb_pkg::chan_req_t      CHAN_REQ,
  input wire int_arb_pkg::ack_t           CHAN_ACK,
  input wire int_arb_pkg::mem_req_t       MEM_REQ,
  input wire logic [7:0]                  MEM_RDATA,
  input wire logic                        MEM_DONE,
  // Results
  input wire logic                        PC_LOAD,
  input wire logic                        FLAGS_LOAD,
  input wire logic [int_arb_pkg::FLAG_W-1:0] FLAGS_OUT,
  input wire logic                        BUSY
);
  import int_arb_pkg::*;
  logic blk_ff;
  logic nxt_blk;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  function automatic logic beats(input chan_req_t r, input ack_t a);
    logic b;
    b = 1'b0;
    for (int j = 0; j < NUM_CH; j++)
      if (r.pend[j] && (r.channel_priority_level[j*3 +: 3] < a.channel_priority_level ||
          (j < a.chan && r.channel_priority_level[j*3 +: 3] == a.channel_priority_level)))
        b = 1'b1;
    return b;
  endfunction : beats
  // Register writes to control may also set the enable, so they unblock too.
  assign nxt_blk = (blk_ff | CHAN_ACK.ack) &
                   ~(EI_INSTR | IRET_INSTR | (REG_WR & (REG_ADDR == ADDR_CTRL)));
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      blk_ff <= 1'b0;
    end else begin
      blk_ff <= nxt_blk;
    end
  end
  AST_ACK_SLOT: assert property (CHAN_ACK.ack |-> INSTR_BOUNDARY && !BUSY)
    else $error("ack outside an idle slot");
  AST_ACK_FIELDS: assert property (CHAN_ACK.ack |->
    CHAN_REQ.pend[CHAN_ACK.chan] &&
    CHAN_REQ.channel_priority_level[CHAN_ACK.chan*3 +: 3] == CHAN_ACK.channel_priority_level &&
    CHAN_REQ.vec[CHAN_ACK.chan*8 +: 8] == CHAN_ACK.vec)
    else $error("ack fields differ from the channel");
  AST_ACK_WIN: assert property (CHAN_ACK.ack |-> !beats(CHAN_REQ, CHAN_ACK))
    else $error("ack is not the best request");
  AST_ACK_LEVEL: assert property (CHAN_ACK.ack |-> CHAN_ACK.channel_priority_level != 3'h7)
    else $error("level seven acknowledged");
  AST_ACK_GATE: assert property (CHAN_ACK.ack |-> !blk_ff)
    else $error("ack while the enable is cleared");
  AST_PUSH_FIRST: assert property (CHAN_ACK.ack |=> BUSY && MEM_REQ.push &&
    MEM_REQ.wdata == $past(PC_IN[7:0]))
    else $error("entry does not push PC low first");
  AST_FLAGS_POP: assert property (FLAGS_LOAD |->
    $past(MEM_REQ.pop && MEM_DONE) && FLAGS_OUT == $past(MEM_RDATA))
    else $error("flags loaded without a pop");
  AST_PC_SRC: assert property (PC_LOAD |->
    $past(MEM_DONE && (MEM_REQ.rd || MEM_REQ.pop)))
    else $error("PC loaded without a memory byte");
  AST_MEM_ONE: assert property ($onehot0({MEM_REQ.push, MEM_REQ.pop, MEM_REQ.rd}))
    else $error("several memory requests at once");
  COV_ACK: cover property (CHAN_ACK.ack);
  COV_FLAGS: cover property (FLAGS_LOAD);
  COV_NEST: cover property (EI_INSTR ##[1:200] CHAN_ACK.ack);
endmodule : int_arb_sva

bind interrupt_arbitration_nesting int_arb_sva u_sva (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .INSTR_BOUNDARY(INSTR_BOUNDARY), .EI_INSTR(EI_INSTR),
  .IRET_INSTR(IRET_INSTR), .PC_IN(PC_IN), .CHAN_REQ(CHAN_REQ),
  .CHAN_ACK(CHAN_ACK), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA),
  .MEM_DONE(MEM_DONE), .PC_LOAD(PC_LOAD), .FLAGS_LOAD(FLAGS_LOAD),
  .FLAGS_OUT(FLAGS_OUT), .BUSY(BUSY));

// ---- verification/int_mem_model.sv ----
// Stack and vector memory model answering the sequencer with a set delay.
`timescale 1ns/1ps
module int_mem_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Requests and answers
  input  wire int_arb_pkg::mem_req_t req,
  input  wire logic [1:0]           dly,
  output logic [7:0]                rdata,
  output logic                      done
);
  import int_arb_pkg::*;
  logic [7:0] stk [0:15];
  logic [3:0] sp;
  logic [1:0] cnt;
  // Outside a done cycle the data toggles, so a stale byte is never taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 4'h0;
      cnt <= 2'h0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else if (done) begin
      done <= 1'b0;
      cnt <= 2'h0;
      rdata <= ~rdata;
      if (req.push) begin
        stk[sp] <= req.wdata;
        sp <= sp + 4'h1;
      end
    end else if ((req.push | req.pop | req.rd) && cnt == dly) begin
      done <= 1'b1;
      if (req.pop) begin
        rdata <= stk[sp - 4'h1];
        sp <= sp - 4'h1;
      end else begin
        rdata <= req.addr[7:0] ^ req.addr[15:8] ^ 8'h5A;
      end
    end else begin
      cnt <= cnt + {1'b0, (req.push | req.pop | req.rd)};
      rdata <= ~rdata;
    end
  end
endmodule : int_mem_model

// ---- verification/tb_interrupt_arbitration_nesting.sv ----
// Self-checking bench for the interrupt arbitration block.
`timescale 1ns/1ps
module tb_interrupt_arbitration_nesting;
  import int_arb_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        bnd = 1'b0, ei = 1'b0, iret = 1'b0, mdone, pcl, fll, busy;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, fl_in = 8'h00, rdata, mrd, flo, fseg;
  logic [7:0]  iseg, cseg, nf, v, qfl [$];
  logic [15:0] pc_in = 16'h0000, pco, np, qpc [$];
  logic [1:0]  dly = 2'h0;
  logic [2:0]  wp;
  logic [31:0] rnd = 32'hB434;
  logic        md, ss;
  chan_req_t   req = '0, nreq;
  ack_t        ack;
  mem_req_t    mreq;
  int          n_fail = 0, check_count = 0, cyc = 0, w;
  always #20 clk = ~clk;
  interrupt_arbitration_nesting dut_u (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CHAN_REQ(req),
    .CHAN_ACK(ack), .INSTR_BOUNDARY(bnd), .EI_INSTR(ei), .DI_INSTR(1'b0),
    .IRET_INSTR(iret), .PC_IN(pc_in), .FLAGS_IN(fl_in), .MEM_REQ(mreq),
    .MEM_RDATA(mrd), .MEM_DONE(mdone), .PC_LOAD(pcl), .PC_OUT(pco),
    .FLAGS_LOAD(fll), .FLAGS_OUT(flo), .FETCH_SEG(fseg), .BUSY(busy));
  int_mem_model u_mem (.clk(clk), .rst_n(rst_n), .req(mreq), .dly(dly),
    .rdata(mrd), .done(mdone));
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lf
  function automatic logic [7:0] vb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : vb
  // Strict compare keeps the lowest index among equal levels.
  function automatic int win(input chan_req_t r, input logic [2:0] current_priority_level);
    int b;
    logic [2:0] p;
    b = 0;
    p = current_priority_level;
    for (int i = 0; i < NUM_CH; i++)
      if (r.pend[i] && r.channel_priority_level[i*3 +: 3] < p) begin
        b = i;
        p = r.channel_priority_level[i*3 +: 3];
      end
    return b;
  endfunction : win
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(16'(rdata), 16'(e));
  endtask : rreg
  task automatic serve(input logic [2:0] current_priority_level);
    rnd = lf(rnd);
    np = rnd[15:0];
    nf = rnd[23:16];
    w = win(nreq, current_priority_level);
    wp = nreq.channel_priority_level[w*3 +: 3];
    v = nreq.vec[w*8 +: 8];
    qpc.push_back(np);
    qfl.push_back(nf);
    @(posedge clk);
    pc_in <= np;
    fl_in <= nf;
    dly <= rnd[25:24];
    req <= nreq;
    bnd <= 1'b1;
    @(negedge clk);
    while (ack.ack !== 1'b1) @(negedge clk);
    chk(16'(ack.chan), 16'(w));
    chk(16'({ack.channel_priority_level, ack.vec}), {5'h00, wp, v});
    @(posedge clk);
    req.pend[w] <= 1'b0;
    @(negedge clk);
    while (pcl !== 1'b1) @(negedge clk);
    chk(pco, {vb({iseg, v}), vb({iseg, v} + 16'h0001)});
    while (busy !== 1'b0) @(negedge clk);
  endtask : serve
  task automatic ret();
    @(posedge clk);
    iret <= 1'b1;
    bnd <= 1'b0;
    req.pend <= '0;
    @(posedge clk);
    iret <= 1'b0;
    @(negedge clk);
    while (fll !== 1'b1) @(negedge clk);
    chk(16'(flo), 16'(qfl.pop_back()));
    while (pcl !== 1'b1) @(negedge clk);
    chk(pco, qpc.pop_back());
    while (busy !== 1'b0) @(negedge clk);
  endtask : ret
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rreg(ADDR_CTRL, 8'h00);
    rreg(ADDR_CPL, 8'h07);
    for (int i = 0; i < 12; i++) begin
      md = i[0];
      ss = i[1];
      rnd = lf(rnd);
      iseg = rnd[7:0];
      cseg = rnd[15:8];
      nreq = '0;
      for (int j = 0; j < NUM_CH; j++) begin
        rnd = lf(rnd);
        nreq.pend[j] = rnd[4];
        nreq.channel_priority_level[j*3 +: 3] = (i == 0) ? 3'h3 : rnd[2:0];
        nreq.vec[j*8 +: 8] = rnd[15:8];
      end
      nreq.pend[15] = 1'b1;
      nreq.channel_priority_level[45 +: 3] = 3'h6;
      wreg(ADDR_CTRL, {5'h00, ss, 1'b1, md});
      wreg(ADDR_CSEG, cseg);
      wreg(ADDR_ISEG, iseg);
      serve(3'h7);
      chk(16'(fseg), 16'(iseg));
      chk({u_mem.stk[1], u_mem.stk[0]}, np);
      chk(16'(u_mem.sp), ss ? 16'h0004 : 16'h0003);
      chk(16'(u_mem.stk[u_mem.sp - 4'h1]), 16'(nf));
      if (ss) chk(16'(u_mem.stk[2]), 16'(cseg));
      rreg(ADDR_CTRL, {5'h00, ss, 1'b0, md});
      rreg(ADDR_CSEG, ss ? iseg : cseg);
      rreg(ADDR_CPL, md ? {5'h00, wp} : 8'h07);
      rreg(ADDR_NEST, md ? 8'h80 : 8'h00);
      ret();
      rreg(ADDR_CTRL, {5'h00, ss, 1'b1, md});
      rreg(ADDR_CSEG, cseg);
      rreg(ADDR_CPL, 8'h07);
      chk(16'(fseg), 16'(cseg));
    end
    wreg(ADDR_CTRL, 8'h06);
    nreq = '0;
    nreq.pend[5] = 1'b1;
    nreq.channel_priority_level[15 +: 3] = 3'h4;
    serve(3'h7);
    @(posedge clk);
    ei <= 1'b1;
    @(posedge clk);
    ei <= 1'b0;
    nreq.pend = 16'h0200;
    nreq.channel_priority_level[27 +: 3] = 3'h6;
    serve(3'h7);
    rreg(ADDR_CPL, 8'h07);
    rreg(ADDR_NEST, 8'h00);
    ret();
    ret();
    chk(16'(fseg), 16'(cseg));
    wreg(ADDR_CTRL, 8'h03);
    nreq = '0;
    nreq.pend[5] = 1'b1;
    nreq.channel_priority_level[15 +: 3] = 3'h4;
    serve(3'h7);
    @(posedge clk);
    ei <= 1'b1;
    @(posedge clk);
    ei <= 1'b0;
    nreq = '0;
    nreq.pend[9] = 1'b1;
    nreq.channel_priority_level[27 +: 3] = 3'h1;
    serve(3'h4);
    rreg(ADDR_NEST, 8'h90);
    ret();
    rreg(ADDR_CPL, 8'h04);
    rreg(ADDR_NEST, 8'h80);
    chk(16'(fseg), 16'(iseg));
    ret();
    chk(16'(fseg), 16'(cseg));
    rreg(4'hF, 8'h00);
    conclude();
  end
endmodule : tb_interrupt_arbitration_nesting
